// ### shared/pppc_consts.svh
// Constants for the port power protection controller
`ifndef PPPC_CONSTS_SVH
`define PPPC_CONSTS_SVH
// Register byte offsets
`define PPPC_CTRL_OFS 4'h0
`define PPPC_LIMIT_OFS 4'h4
`define PPPC_CHARGE_OFS 4'h8
`define PPPC_STATUS_OFS 4'hC
// Control register fields
`define PPPC_CTRL_EN_BIT 0
`define PPPC_CTRL_ACT_LSB 1
`define PPPC_CTRL_RST_BIT 3
`define PPPC_CTRL_DIS_BIT 4
`define PPPC_CTRL_LIM_LSB 5
`define PPPC_CTRL_CC_BIT 8
// Status register write-one-to-clear bit
`define PPPC_ST_DFAULT_BIT 1
// Reset values
`define PPPC_EN_RST 1'h0
`define PPPC_ACT_RST 2'h1
`define PPPC_LIM_RST 3'h7
`define PPPC_CC_RST 1'h1
`define PPPC_LIMIT_RST 16'hFFFF
// Lowest current limit step
`define PPPC_LIM_MIN 3'h0
// Clock rate and times in milliseconds
`define PPPC_CLK_HZ 25000000
`define PPPC_CYC_PER_MS (`PPPC_CLK_HZ / 1000)
`define PPPC_RETRY_MS 200
`define PPPC_RECOVER_MS 1000
`define PPPC_DISCH_MS 200
`define PPPC_TICK_MS 1
// Milliampere-milliseconds in one milliampere-hour
`define PPPC_MAMS_PER_MAH 22'h36EE80
`endif

// ### shared/pppc_pkg.sv
// Types for the port power protection controller
package pppc_pkg;
  // Power state of the port
  typedef enum logic [1:0] {
    PS_SLEEP = 2'b00,
    PS_DETECT = 2'b01,
    PS_ACTIVE = 2'b10,
    PS_ERROR = 2'b11
  } pppc_pwr_t;
  // Dynamic thermal management phases
  typedef enum logic [1:0] {
    TH_WATCH = 2'b00,
    TH_RETRY = 2'b01,
    TH_HOLD = 2'b10,
    TH_RECOVER = 2'b11
  } pppc_therm_t;
  // Action once the charge reached_flag_a is used up
  typedef enum logic [1:0] {
    RA_REPORT = 2'b00,
    RA_REP_DISC = 2'b01,
    RA_SLEEP = 2'b10,
    RA_IGNORE = 2'b11
  } pppc_ract_t;
endpackage

// ### design/pppc_sync.sv
// Two-stage synchroniser for pin inputs
module pppc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // Pins and synchronised copy
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  // First stage, read only by the second
  logic [W-1:0] meta;

  // Both stages clear on reset
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      meta <= '0;
      sync_o <= '0;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule // pppc_sync

// ### design/pppc_top.sv
// Thermal, discharge and charge rationing control of a USB port switch
`include "pppc_consts.svh"
module pppc_top #(
  parameter int unsigned RETRY_CYC = `PPPC_RETRY_MS * `PPPC_CYC_PER_MS,
  parameter int unsigned RECOVER_CYC = `PPPC_RECOVER_MS * `PPPC_CYC_PER_MS,
  parameter int unsigned DISCH_CYC = `PPPC_DISCH_MS * `PPPC_CYC_PER_MS,
  parameter int unsigned TICK_CYC = `PPPC_TICK_MS * `PPPC_CYC_PER_MS
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Control pins
  input wire logic port_power_enable_i,
  input wire logic emulation_enable_i,
  input wire logic mode_select_a_i,
  input wire logic mode_select_b_i,
  input wire logic bypass_select_i,
  // Comparator pins
  input wire logic temp_over_reg_i,
  input wire logic temp_below_reg_hyst_i,
  input wire logic temp_over_shutdown_i,
  input wire logic temp_below_shutdown_hyst_i,
  input wire logic bus_below_test_i,
  input wire logic source_undervoltage_i,
  // Detection and emulation
  input wire logic removal_detect_i,
  input wire logic dedicated_charger_cycle_i,
  input wire logic profile_accepted_i,
  input wire logic profile_apply_i,
  input wire logic error_recover_i,
  input wire logic [11:0] bus_current_ma_i,
  // Switch and status outputs
  output logic port_switch_on_o,
  output logic bypass_switch_on_o,
  output logic bus_discharge_o,
  output logic [2:0] current_limit_setting_o,
  output logic constant_current_mode_o,
  output logic cc_floor_current_o,
  output logic profile_remove_o,
  output logic hs_data_switch_o,
  output logic monitor_en_o,
  output logic alert_n_o,
  output pppc_pkg::pppc_pwr_t power_state_o
);
  import pppc_pkg::*;

  // Step down one limit, saturating at the floor
  function automatic logic [2:0] lim_dec(input logic [2:0] x);
    return (x == `PPPC_LIM_MIN) ? x : 3'(x - 3'h1);
  endfunction

  // Power state asked for by the control pins
  function automatic pppc_pwr_t ctl_decode(input logic e, input logic a, input logic b,
                                           input logic p);
    if ({e, a, b} == 3'h0) return PS_SLEEP;
    return p ? PS_ACTIVE : PS_DETECT;
  endfunction

  // Synchronised pins
  logic pe, em, ma, mb, bs, t_over, t_cool, tsd_over, tsd_cool, vb_low, uv, rem, dce, acc;
  logic [13:0] syn;
  // Control register fields
  logic reached_flag_a_en, reached_flag_a_rst, dis_cmd, cc_sel, dfault;
  pppc_ract_t ract;
  logic [2:0] prog_lim;
  logic [15:0] limit;
  // Rationing state
  logic [31:0] tick;
  logic [21:0] sub, sub_sum;
  logic [15:0] charge;
  logic reached;
  // Thermal state
  pppc_therm_t th_state;
  logic [31:0] th_cnt, dis_cnt;
  logic [2:0] current_limit_setting, s_current_limit_setting;
  logic fallback, s_fb, s_hold, tsd, prof_rm, adjusted;
  // Edge history and source tracking
  logic pe_q, rem_q, uv_q, last_port;
  logic [4:0] ctl_prev;
  pppc_pwr_t ctl_st, ctl_st_q;
  // Combinational decisions
  logic rq, wr, alert_act, port_block, byp_block, force_sleep;
  logic want_port, want_byp, src_trig, dis_trig, dis_end, dis_fail;
  logic [31:0] rd_mux;

  // Comparators and controls cross from the analog side
  // two-stage input capture
  pppc_sync #(.W(14)) u_sync (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .async_i({port_power_enable_i, emulation_enable_i, mode_select_a_i, mode_select_b_i,
              bypass_select_i, temp_over_reg_i, temp_below_reg_hyst_i, temp_over_shutdown_i,
              temp_below_shutdown_hyst_i, bus_below_test_i, source_undervoltage_i,
              removal_detect_i, dedicated_charger_cycle_i, profile_accepted_i}),
    .sync_o(syn)
  );
  assign {pe, em, ma, mb, bs, t_over, t_cool, tsd_over, tsd_cool, vb_low, uv, rem, dce, acc} = syn;
  assign ctl_st = ctl_decode(em, ma, mb, pe);

  // Bus request; waitrequest drops for one cycle per access
  assign rq = avs_read_i | avs_write_i;
  assign wr = avs_write_i & ~avs_waitrequest_o;

  // One wait state, then the answer edge
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= ~(rq & avs_waitrequest_o);
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    case (avs_address_i)
      `PPPC_CTRL_OFS: rd_mux = {23'h0, cc_sel, prog_lim, 2'h0, ract, reached_flag_a_en};
      `PPPC_LIMIT_OFS: rd_mux = {16'h0, limit};
      `PPPC_CHARGE_OFS: rd_mux = {16'h0, charge};
      `PPPC_STATUS_OFS: begin
        rd_mux = {22'h0, bus_discharge_o, power_state_o, current_limit_setting, fallback, tsd, dfault, reached};
      end
      default: rd_mux = 32'h0;
    endcase
  end

  // Read data captured while waitrequest is still high
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      avs_readdata_o <= 32'h0;
    end else if (avs_read_i && avs_waitrequest_o) begin
      avs_readdata_o <= rd_mux;
    end
  end

  // Control and limit registers; reset and command bits are pulses
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      reached_flag_a_en <= `PPPC_EN_RST;
      ract <= pppc_ract_t'(`PPPC_ACT_RST);
      prog_lim <= `PPPC_LIM_RST;
      cc_sel <= `PPPC_CC_RST;
      limit <= `PPPC_LIMIT_RST;
      reached_flag_a_rst <= 1'b0;
      dis_cmd <= 1'b0;
    end else begin
      reached_flag_a_rst <= 1'b0;
      dis_cmd <= 1'b0;
      if (wr && avs_address_i == `PPPC_CTRL_OFS) begin
        if (avs_byteenable_i[0]) begin
          reached_flag_a_en <= avs_writedata_i[`PPPC_CTRL_EN_BIT];
          ract <= pppc_ract_t'(avs_writedata_i[`PPPC_CTRL_ACT_LSB +: 2]);
          reached_flag_a_rst <= avs_writedata_i[`PPPC_CTRL_RST_BIT];
          dis_cmd <= avs_writedata_i[`PPPC_CTRL_DIS_BIT];
          prog_lim <= avs_writedata_i[`PPPC_CTRL_LIM_LSB +: 3];
        end
        if (avs_byteenable_i[1]) begin
          cc_sel <= avs_writedata_i[`PPPC_CTRL_CC_BIT];
        end
      end
      if (wr && avs_address_i == `PPPC_LIMIT_OFS) begin
        if (avs_byteenable_i[0]) limit[7:0] <= avs_writedata_i[7:0];
        if (avs_byteenable_i[1]) limit[15:8] <= avs_writedata_i[15:8];
      end
    end
  end

  // Discharge fault flag; a new fault beats a clear
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      dfault <= 1'b0;
    end else if (dis_fail) begin
      dfault <= 1'b1;
    end else if (wr && avs_address_i == `PPPC_STATUS_OFS && avs_byteenable_i[0] &&
                 avs_writedata_i[`PPPC_ST_DFAULT_BIT]) begin
      dfault <= 1'b0;
    end
  end

  // What the used-up reached_flag_a does, live from the current code
  // report and report-disconnect codes raise the alert
  assign alert_act = reached && (ract == RA_REPORT || ract == RA_REP_DISC);
  assign port_block = reached && (ract == RA_REP_DISC || ract == RA_SLEEP);
  assign byp_block = reached && ract == RA_REP_DISC;
  assign force_sleep = reached && ract == RA_SLEEP;

  // Switch wishes before discharge gating
  // shutdown latch blocks the switch
  assign want_port = power_state_o == PS_ACTIVE && !tsd && !uv && th_state != TH_RETRY &&
                     !port_block;
  assign want_byp = power_state_o == PS_DETECT && bs && !byp_block;
  assign src_trig = (want_port && !last_port) || (want_byp && last_port);

  // Discharge causes; thermal stepping is deliberately absent
  // pin, removal, undervoltage, sleep
  assign dis_trig = (!force_sleep && pe_q && !pe) || (rem && !rem_q) ||
                    (uv && !uv_q && port_switch_on_o) ||
                    (!force_sleep && ctl_st == PS_SLEEP && ctl_st_q != PS_SLEEP) ||
                    profile_apply_i || (power_state_o == PS_ERROR && error_recover_i) ||
                    (dis_cmd && power_state_o == PS_ACTIVE) || src_trig;
  assign dis_end = bus_discharge_o && dis_cnt == DISCH_CYC - 1;
  // bus still high at the end
  assign dis_fail = dis_end && !vb_low;

  // Edge history of pins and of the last supplying switch
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pe_q <= 1'b0;
      rem_q <= 1'b0;
      uv_q <= 1'b0;
      ctl_prev <= 5'h0;
      ctl_st_q <= PS_SLEEP;
      last_port <= 1'b0;
    end else begin
      pe_q <= pe;
      rem_q <= rem;
      uv_q <= uv;
      ctl_prev <= {pe, em, ma, mb, bs};
      ctl_st_q <= ctl_st;
      if (src_trig) last_port <= want_port;
    end
  end

  // Discharge interval; a trigger during one is absorbed by it
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      bus_discharge_o <= 1'b0;
      dis_cnt <= 32'h0;
    end else if (!bus_discharge_o) begin
      dis_cnt <= 32'h0;
      if (dis_trig) bus_discharge_o <= 1'b1;
    end else if (dis_end) begin
      bus_discharge_o <= 1'b0;
      dis_cnt <= 32'h0;
    end else begin
      dis_cnt <= dis_cnt + 32'h1;
    end
  end

  // Power state; error outranks the rationing sleep
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      power_state_o <= PS_SLEEP;
    end else if (dis_fail) begin
      // fault enters error, even against a recovery pulse
      power_state_o <= PS_ERROR;
    end else if (power_state_o == PS_ERROR) begin
      if (error_recover_i) power_state_o <= ctl_st;
    end else if (force_sleep) begin
      power_state_o <= PS_SLEEP;
    end else begin
      power_state_o <= ctl_st;
    end
  end

  // Result of one thermal step from the present limit
  always_comb begin
    s_current_limit_setting = current_limit_setting;
    s_fb = fallback;
    s_hold = 1'b0;
    if (current_limit_setting != `PPPC_LIM_MIN) begin
      s_current_limit_setting = lim_dec(current_limit_setting);
    end else if (cc_sel && !fallback) begin
      s_current_limit_setting = lim_dec(prog_lim);
      s_fb = 1'b1;
    end else begin
      s_hold = 1'b1;
    end
  end
  assign adjusted = current_limit_setting != prog_lim || fallback;

  // Dynamic thermal management
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      th_state <= TH_WATCH;
      th_cnt <= 32'h0;
      current_limit_setting <= `PPPC_LIM_RST;
      fallback <= 1'b0;
    end else begin
      unique case (th_state)
        TH_WATCH: begin
          th_cnt <= 32'h0;
          if (t_over) begin
            current_limit_setting <= s_current_limit_setting;
            fallback <= s_fb;
            th_state <= s_hold ? TH_HOLD : TH_RETRY;
          end else if (!adjusted || (t_cool && !fallback)) begin
            current_limit_setting <= prog_lim;
          end else if (t_cool) begin
            th_state <= TH_RECOVER;
          end
        end
        TH_RETRY: begin
          if (th_cnt == RETRY_CYC - 1) begin
            th_cnt <= 32'h0;
            th_state <= TH_WATCH;
          end else begin
            th_cnt <= th_cnt + 32'h1;
          end
        end
        TH_HOLD: begin
          if (t_cool && fallback) begin
            th_state <= TH_RECOVER;
          end else if (t_cool) begin
            current_limit_setting <= prog_lim;
            th_state <= TH_WATCH;
          end
        end
        TH_RECOVER: begin
          if (t_over) begin
            th_cnt <= 32'h0;
            th_state <= TH_WATCH;
          end else if (th_cnt == RECOVER_CYC - 1) begin
            th_cnt <= 32'h0;
            current_limit_setting <= prog_lim;
            fallback <= 1'b0;
            th_state <= TH_WATCH;
          end else begin
            th_cnt <= th_cnt + 32'h1;
          end
        end
      endcase
    end
  end

  // Shutdown latch with its own hysteresis
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      tsd <= 1'b0;
    end else if (tsd_over) begin
      tsd <= 1'b1;
    end else if (tsd_cool) begin
      tsd <= 1'b0;
    end
  end

  // Profile dropped on heat in the charger cycle
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      prof_rm <= 1'b0;
    end else if (t_over && dce && acc) begin
      prof_rm <= 1'b1;
    end else if ({pe, em, ma, mb, bs} != ctl_prev) begin
      prof_rm <= 1'b0;
    end
  end

  // Charge accumulation; removal events do not touch it
  assign sub_sum = sub + {10'h0, bus_current_ma_i};
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || reached_flag_a_rst || !reached_flag_a_en) begin
      tick <= 32'h0;
      sub <= 22'h0;
      charge <= 16'h0;
      reached <= 1'b0;
    end else begin
      if (charge >= limit) reached <= 1'b1;
      if (power_state_o == PS_ACTIVE) begin
        if (tick == TICK_CYC - 1) begin
          tick <= 32'h0;
          if (sub_sum >= `PPPC_MAMS_PER_MAH) begin
            sub <= 22'(sub_sum - `PPPC_MAMS_PER_MAH);
            if (charge != 16'hFFFF) charge <= charge + 16'h1;
          end else begin
            sub <= sub_sum;
          end
        end else begin
          tick <= tick + 32'h1;
        end
      end
    end
  end

  // Registered pin outputs
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      port_switch_on_o <= 1'b0;
      bypass_switch_on_o <= 1'b0;
      current_limit_setting_o <= `PPPC_LIM_RST;
      constant_current_mode_o <= 1'b0;
      cc_floor_current_o <= 1'b0;
      profile_remove_o <= 1'b0;
      hs_data_switch_o <= 1'b0;
      monitor_en_o <= 1'b1;
      alert_n_o <= 1'b1;
    end else begin
      port_switch_on_o <= want_port && !bus_discharge_o && !dis_trig;
      bypass_switch_on_o <= want_byp && !bus_discharge_o && !dis_trig;
      current_limit_setting_o <= current_limit_setting;
      constant_current_mode_o <= cc_sel && !fallback;
      cc_floor_current_o <= fallback;
      profile_remove_o <= prof_rm || port_block;
      hs_data_switch_o <= power_state_o == PS_ACTIVE && !force_sleep;
      monitor_en_o <= !force_sleep;
      alert_n_o <= !alert_act;
    end
  end

  // Checks on the behaviour above
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  tsd_off_a: assert property (tsd |=> !port_switch_on_o)
    else $error("switch on during shutdown");
  retry_open_a: assert property (th_state == TH_RETRY |=> !port_switch_on_o)
    else $error("switch closed during thermal retry");
  step_down_a: assert property (th_state == TH_WATCH && t_over && current_limit_setting != 3'h0
    |=> current_limit_setting == 3'($past(current_limit_setting) - 3'h1) && th_state == TH_RETRY)
    else $error("limit not stepped down");
  trip_fallback_a: assert property (th_state == TH_WATCH && t_over && current_limit_setting == 3'h0 &&
    cc_sel && !fallback |=> fallback && current_limit_setting == lim_dec(prog_lim) ##1 cc_floor_current_o)
    else $error("no trip fall-back");
  no_heat_disch_a: assert property (th_state == TH_WATCH && t_over &&
    !bus_discharge_o && {pe, rem, uv, ctl_st} == {pe_q, rem_q, uv_q, ctl_st_q} &&
    !profile_apply_i && !dis_cmd && !error_recover_i && !src_trig |=> !bus_discharge_o)
    else $error("discharge started by heat");
  disch_fault_a: assert property (dis_end && !vb_low
    |=> dfault && power_state_o == PS_ERROR)
    else $error("discharge fault missed");
  reached_flag_a_noerr_a: assert property (power_state_o != PS_ERROR && !dis_fail
    |=> power_state_o != PS_ERROR)
    else $error("error without discharge fault");
  report_alert_a: assert property (reached && ract == RA_REPORT
    |=> !alert_n_o && (port_switch_on_o == $past(want_port && !bus_discharge_o && !dis_trig)))
    else $error("report code misbehaves");
  disc_off_a: assert property (reached && ract == RA_REP_DISC
    |=> !bypass_switch_on_o && !port_switch_on_o && profile_remove_o)
    else $error("disconnect code leaves a switch on");
  reached_flag_a_sleep_a: assert property (reached && ract == RA_SLEEP &&
    power_state_o != PS_ERROR && !dis_fail
    |=> power_state_o == PS_SLEEP && !monitor_en_o && !hs_data_switch_o)
    else $error("sleep code not applied");
  reached_flag_a_reset_a: assert property (reached_flag_a_rst |=> !reached && charge == 16'h0)
    else $error("rationing reset incomplete");
  bus_answer_a: assert property (rq && avs_waitrequest_o
    |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer timing wrong");

  fallback_c: cover property ($rose(fallback));
  reached_c: cover property ($rose(reached));
  dfault_c: cover property ($rose(dfault));
  recover_c: cover property (th_state == TH_RECOVER ##1 th_state == TH_WATCH && !fallback);
endmodule // pppc_top

// ### dv/pppc_port_model.sv
// Behavioural model of the attached port: bus level and load current
module pppc_port_model (
  // Clock
  input wire logic sys_clk_i,
  // Device outputs and bench fault control
  input wire logic port_switch_on_i,
  input wire logic bus_discharge_i,
  input wire logic stuck_i,
  // Back to the device
  output logic bus_below_test_o,
  output logic [11:0] bus_current_ma_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int drain_cnt = 0; // Discharge cycles seen since power went off
  // Bus falls only after a real drain, never when stuck
  always @(posedge sys_clk_i) begin
    if (port_switch_on_i) drain_cnt <= 0;
    else if (bus_discharge_i && drain_cnt < 3) drain_cnt <= drain_cnt + 1;
  end
  assign bus_below_test_o = (drain_cnt >= 3) && !stuck_i;
  // Fixed 1000 mA load while powered
  assign bus_current_ma_o = port_switch_on_i ? 12'h3E8 : 12'h000;
endmodule // pppc_port_model

// ### dv/pppc_top_tb_top.sv
// Self-checking bench for the port power protection controller
`include "pppc_consts.svh"
module pppc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pppc_pkg::*;
  logic sys_clk_i = 0, srst_i = 1, rd = 0, wr = 0, port_power_enable = 0, emulation_enable = 0, quiet = 0;
  logic t_reg = 0, t_cool = 1, t_sd = 0, t_sd_cool = 1, stuck = 0, err_rec = 0;
  logic rem_det = 0, prof_apply = 0, dce = 0, acc = 0, byp_sel = 0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rv, rdata;
  logic waitreq, sw_on, byp_on, disch, ccm, floor, prem, hs, mon, alert_n, bus_low;
  logic [2:0] lim;
  logic [11:0] cur;
  pppc_pwr_t pstate;
  int miscompares = 0, total_checks = 0, cycles = 0;
  logic [1:0] codes [4] = '{2'h3, 2'h0, 2'h1, 2'h2}; // Action order
  pppc_top #(.RETRY_CYC(20), .RECOVER_CYC(40), .DISCH_CYC(10), .TICK_CYC(4)) i_pppc_top (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .port_power_enable_i(port_power_enable),
    .emulation_enable_i(emulation_enable), .mode_select_a_i(quiet), .mode_select_b_i(quiet),
    .bypass_select_i(byp_sel), .temp_over_reg_i(t_reg), .temp_below_reg_hyst_i(t_cool),
    .temp_over_shutdown_i(t_sd), .temp_below_shutdown_hyst_i(t_sd_cool),
    .bus_below_test_i(bus_low), .source_undervoltage_i(quiet), .removal_detect_i(rem_det),
    .dedicated_charger_cycle_i(dce), .profile_accepted_i(acc), .profile_apply_i(prof_apply),
    .error_recover_i(err_rec), .bus_current_ma_i(cur), .port_switch_on_o(sw_on),
    .bypass_switch_on_o(byp_on), .bus_discharge_o(disch), .current_limit_setting_o(lim),
    .constant_current_mode_o(ccm), .cc_floor_current_o(floor), .profile_remove_o(prem),
    .hs_data_switch_o(hs), .monitor_en_o(mon), .alert_n_o(alert_n), .power_state_o(pstate));
  pppc_port_model i_pppc_port_model (.sys_clk_i(sys_clk_i), .port_switch_on_i(sw_on),
    .bus_discharge_i(disch), .stuck_i(stuck), .bus_below_test_o(bus_low),
    .bus_current_ma_o(cur));
  // Clock
  initial forever #20 sys_clk_i = ~sys_clk_i;
  // Hang guard, far above the expected run length
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles > 5000) begin
      miscompares++;
      stop_test();
    end
  end
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task stop_test;
    if (miscompares == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Bus cycle held until waitrequest is sampled low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do @(posedge sys_clk_i); while (waitreq !== 1'b0);
    rv = rdata;
    wr <= 0;
    rd <= 0;
  endtask
  task wait_state(input pppc_pwr_t s);
    for (int i = 0; i < 300 && pstate !== s; i++) @(posedge sys_clk_i);
  endtask
  task wait_sw;
    for (int i = 0; i < 300 && sw_on !== 1'b1; i++) @(posedge sys_clk_i);
    check("switch on", sw_on, 1'b1);
  endtask
  // Any discharge start shows within a few cycles of its cause
  task wait_disch(input string what);
    for (int i = 0; i < 20 && disch !== 1'b1; i++) @(posedge sys_clk_i);
    check(what, disch, 1'b1);
  endtask
  initial begin
    repeat (4) @(posedge sys_clk_i);
    srst_i <= 0;
    bus(0, `PPPC_CTRL_OFS, 0);
    check("ctrl reset", rv, 32'h1E2);
    bus(0, `PPPC_LIMIT_OFS, 0);
    check("limit reset", rv, 32'hFFFF);
    bus(1, 4'h1, 32'hFFFFFFFF);
    bus(0, 4'h1, 0);
    check("unmapped", rv, 32'h0);
    port_power_enable <= 1;
    emulation_enable <= 1;
    wait_disch("entry discharge");
    wait_sw();
    // Heat: one step down, switch open, no discharge
    t_reg <= 1;
    t_cool <= 0;
    repeat (6) @(posedge sys_clk_i);
    check("step down", lim, 3'h6);
    check("heat opens", sw_on, 1'b0);
    check("no heat discharge", disch, 1'b0);
    for (int i = 0; i < 400 && floor !== 1'b1; i++) @(posedge sys_clk_i);
    check("fall-back floor", floor, 1'b1);
    check("fall-back limit", lim, 3'h6);
    repeat (30) @(posedge sys_clk_i);
    check("keep stepping", lim, 3'h5);
    t_reg <= 0;
    t_cool <= 1;
    repeat (10) @(posedge sys_clk_i);
    check("recover waits", floor, 1'b1);
    for (int i = 0; i < 80 && lim !== 3'h7; i++) @(posedge sys_clk_i);
    check("restored limit", lim, 3'h7);
    check("restored cc", ccm, 1'b1);
    wait_sw();
    // Shutdown heat holds the switch off until below hysteresis
    t_sd <= 1;
    t_sd_cool <= 0;
    repeat (4) @(posedge sys_clk_i);
    t_sd <= 0;
    repeat (20) @(posedge sys_clk_i);
    check("shutdown off", sw_on, 1'b0);
    t_sd_cool <= 1;
    wait_sw();
    // Host discharge with a stuck bus ends in Error
    stuck <= 1;
    bus(1, `PPPC_CTRL_OFS, 32'h1F2);
    wait_state(PS_ERROR);
    check("discharge error", pstate, PS_ERROR);
    bus(0, `PPPC_STATUS_OFS, 0);
    check("fault flag", rv[1], 1'b1);
    bus(1, `PPPC_STATUS_OFS, 32'h2);
    stuck <= 0;
    err_rec <= 1;
    @(posedge sys_clk_i);
    err_rec <= 0;
    wait_state(PS_ACTIVE);
    check("error exit", pstate, PS_ACTIVE);
    wait_sw();
    // Zero reached_flag_a limit: every action code in turn
    bus(1, `PPPC_LIMIT_OFS, 32'h0);
    foreach (codes[k]) begin
      bus(1, `PPPC_CTRL_OFS, 32'h1E1 | (codes[k] << 1));
      repeat (8) @(posedge sys_clk_i);
      check("reached_flag_a switch", sw_on, codes[k] == 0 || codes[k] == 3);
      check("reached_flag_a profile", prem, codes[k] == 1 || codes[k] == 2);
      check("reached_flag_a monitor", mon, codes[k] != 2);
      check("reached_flag_a data sw", hs, codes[k] != 2);
      check("reached_flag_a state", pstate, codes[k] == 2 ? PS_SLEEP : PS_ACTIVE);
      if (codes[k] != 2) check("reached_flag_a alert", alert_n, codes[k] == 3);
    end
    bus(1, `PPPC_LIMIT_OFS, 32'hFFFF);
    bus(1, `PPPC_CTRL_OFS, 32'h1E9);
    bus(0, `PPPC_CHARGE_OFS, 0);
    check("charge cleared", rv, 32'h0);
    bus(0, `PPPC_STATUS_OFS, 0);
    check("reached cleared", rv[0], 1'b0);
    check("alert released", alert_n, 1'b1);
    // Removal and profile application each start a discharge
    rem_det <= 1;
    wait_disch("removal discharge");
    rem_det <= 0;
    wait_sw();
    prof_apply <= 1;
    @(posedge sys_clk_i);
    prof_apply <= 0;
    wait_disch("profile discharge");
    wait_sw();
    // Heat in the charger cycle drops the profile until a control moves
    dce <= 1;
    acc <= 1;
    t_reg <= 1;
    t_cool <= 0;
    repeat (6) @(posedge sys_clk_i);
    check("heat drops profile", prem, 1'b1);
    t_reg <= 0;
    t_cool <= 1;
    repeat (30) @(posedge sys_clk_i);
    check("profile stays out", prem, 1'b1);
    byp_sel <= 1;
    repeat (6) @(posedge sys_clk_i);
    check("control restarts", prem, 1'b0);
    // Supply moves to the bypass switch and back
    port_power_enable <= 0;
    wait_disch("enable off discharge");
    for (int i = 0; i < 60 && byp_on !== 1'b1; i++) @(posedge sys_clk_i);
    check("bypass in detect", byp_on, 1'b1);
    port_power_enable <= 1;
    wait_disch("bypass to port discharge");
    wait_sw();
    // Disconnect code keeps the bypass off, power state still follows pins
    bus(1, `PPPC_CTRL_OFS, 32'h1E3);
    bus(1, `PPPC_LIMIT_OFS, 32'h0);
    port_power_enable <= 0;
    repeat (40) @(posedge sys_clk_i);
    check("reached_flag_a bypass", byp_on, 1'b0);
    check("reached_flag_a port off", sw_on, 1'b0);
    check("reached_flag_a detect", pstate, PS_DETECT);
    stop_test();
  end
endmodule // pppc_top_tb_top
